/* File: src/ptb_telemetry_bank.v */
/*
 * Read-only telemetry register bank of a secondary-side supply controller,
 * reached through an indirect pointer location.
 * Assumes an upstream serial slave turns host traffic into one-cycle
 * write and read strobes, and that the regulation and protection logic
 * deliver live levels and one-cycle cause pulses on i_clk.
 */
// What this block does
// - Current average: sixteen-sample mean in low byte, upper byte zero
// - Voltage average: sixteen-sample mean in low 12 bits, top four zero
// - Primary on-time report: sum of sixteen samples, top four bits zero
// - Rectifier on-time report: sixteen-sample sum across all sixteen bits
// - Live status: overvoltage comparator at bit 0, undervoltage at bit 1
// - Live status: sense pin short bit 3, output short bit 2
// - Live status: system ready bit 14, line sense ready bit 12
// - Live status: voltage command allowed bit 10, over-temperature bit 9
// - Disable causes: overload 6, sense short 4, over 2, under 1, watchdog 0
// - History bits 14..9: auto-restart causes, overload first, under last
// - History bit 7 off command received, bit 0 bypass pin latch-off
// - History bits 6..1: latch-off causes, overload first, under last
// - Calibration offset report, bit 3 is sign, one means negative
// - Host writes sub-address to pointer location, then reads it back there
`include "ptb_telemetry_defs.vh"
`default_nettype none

module ptb_telemetry_bank #(
  parameter CUR_W = 8,
  parameter VOLT_W = 12,
  parameter TON_W = 8,
  parameter TOFF_W = 12
) (
  input wire i_clk,
  input wire i_reset,
  // Access port
  input wire i_wr_stb,
  input wire i_rd_stb,
  input wire [7:0] i_addr,
  input wire [15:0] i_wdata,
  output reg [15:0] o_rdata,
  output reg o_rd_valid,
  output reg o_int_req,
  // Live levels
  input wire i_output_over_flag,
  input wire i_output_under_flag,
  input wire i_output_short_flag,
  input wire i_sense_pin_short_flag,
  input wire i_vout_10pct_high,
  input wire i_vout_4pct_high,
  input wire i_over_temp_fault,
  input wire i_voltage_cmd_allowed_flag,
  input wire i_line_sense_ready,
  input wire i_output_discharge_flag,
  input wire i_system_ready,
  input wire i_interrupt_enable,
  input wire [2:0] i_mode_flags,
  input wire [15:0] i_dac_readback,
  input wire [3:0] i_cal_offset,
  input wire [6:0] i_int_mask,
  // Samples
  input wire i_cur_valid,
  input wire [CUR_W-1:0] i_cur_sample,
  input wire i_volt_valid,
  input wire [VOLT_W-1:0] i_volt_sample,
  input wire i_ton_valid,
  input wire [TON_W-1:0] i_ton_sample,
  input wire i_toff_valid,
  input wire [TOFF_W-1:0] i_toff_sample,
  // Cause pulses
  input wire i_overload_disable_cause,
  input wire i_sense_short_disable_cause,
  input wire i_over_disable_cause,
  input wire i_under_disable_cause,
  input wire i_watchdog_disable_cause,
  input wire [5:0] i_restart_causes,
  input wire [5:0] i_latch_causes,
  input wire i_off_command_received,
  input wire i_bypass_pin_latch_cause,
  input wire [8:0] i_int_events
);

  reg [7:0] ptr_r;
  reg [15:0] live_r;
  reg [2:0] mode_r;
  reg [15:0] dac_r;
  reg [3:0] cal_r;
  reg [6:0] mask_r;
  reg [15:0] dis_r;
  reg [15:0] dis_nxt;
  reg [15:0] hist_r;
  reg [15:0] hist_nxt;
  reg [8:0] int_st_r;
  reg [8:0] int_st_nxt;
  reg [15:0] rdata_nxt;
  wire [CUR_W-1:0] avg_cur;
  wire [VOLT_W-1:0] avg_volt;
  wire [TON_W+3:0] ton_sum;
  wire [TOFF_W+3:0] toff_sum;
  wire ptr_hit;
  wire int_rd;

  assign ptr_hit = (i_addr == `PTB_PTR_ADDR);
  assign int_rd = i_rd_stb && ptr_hit && (ptr_r == `PTB_INT_OFS);

  // --------------------------------------------------------------------
  // Windowed averages and sums
  // --------------------------------------------------------------------
  ptb_window_sum #(.IN_W(CUR_W), .OUT_W(CUR_W), .SHIFT(`PTB_WIN_LOG2))
    u_avg_cur (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_valid(i_cur_valid),
    .i_sample(i_cur_sample),
    .o_value(avg_cur)
  );

  ptb_window_sum #(.IN_W(VOLT_W), .OUT_W(VOLT_W), .SHIFT(`PTB_WIN_LOG2))
    u_avg_volt (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_valid(i_volt_valid),
    .i_sample(i_volt_sample),
    .o_value(avg_volt)
  );

  ptb_window_sum #(.IN_W(TON_W), .OUT_W(TON_W + 4), .SHIFT(0))
    u_ton_sum (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_valid(i_ton_valid),
    .i_sample(i_ton_sample),
    .o_value(ton_sum)
  );

  ptb_window_sum #(.IN_W(TOFF_W), .OUT_W(TOFF_W + 4), .SHIFT(0))
    u_toff_sum (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_valid(i_toff_valid),
    .i_sample(i_toff_sample),
    .o_value(toff_sum)
  );

  // --------------------------------------------------------------------
  // Sticky cause flags: a new event wins over the interrupt read clear, not over reset
  // --------------------------------------------------------------------
  always @* begin
    dis_nxt = dis_r;
    dis_nxt[`PTB_DIS_CVO] = dis_r[`PTB_DIS_CVO] | i_overload_disable_cause;
    dis_nxt[`PTB_DIS_SSC] = dis_r[`PTB_DIS_SSC] |
                            i_sense_short_disable_cause;
    dis_nxt[`PTB_DIS_OV] = dis_r[`PTB_DIS_OV] | i_over_disable_cause;
    dis_nxt[`PTB_DIS_UV] = dis_r[`PTB_DIS_UV] | i_under_disable_cause;
    dis_nxt[`PTB_DIS_WD] = dis_r[`PTB_DIS_WD] | i_watchdog_disable_cause;
    hist_nxt = hist_r;
    // Order from top: overload, bus switch, sense pin, short, over, under
    hist_nxt[`PTB_HIST_AR_MSB:`PTB_HIST_AR_LSB] =
      hist_r[`PTB_HIST_AR_MSB:`PTB_HIST_AR_LSB] | i_restart_causes;
    hist_nxt[`PTB_HIST_LO_MSB:`PTB_HIST_LO_LSB] =
      hist_r[`PTB_HIST_LO_MSB:`PTB_HIST_LO_LSB] | i_latch_causes;
    hist_nxt[`PTB_HIST_CMD] = hist_r[`PTB_HIST_CMD] |
                              i_off_command_received;
    hist_nxt[`PTB_HIST_BPS] = hist_r[`PTB_HIST_BPS] |
                              i_bypass_pin_latch_cause;
    // Status clears on a read of the interrupt word, events still land
    int_st_nxt = (int_rd ? 9'h000 : int_st_r) | i_int_events;
  end

  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      dis_r <= 16'h0000;
      hist_r <= 16'h0000;
      int_st_r <= 9'h000;
    end else begin
      dis_r <= dis_nxt;
      hist_r <= hist_nxt;
      int_st_r <= int_st_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Live snapshot registers
  // --------------------------------------------------------------------
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      live_r <= 16'h0000;
      mode_r <= 3'h0;
      dac_r <= 16'h0000;
      cal_r <= 4'h0;
      mask_r <= 7'h00;
    end else begin
      live_r <= 16'h0000;
      live_r[`PTB_LIVE_OV] <= i_output_over_flag;
      live_r[`PTB_LIVE_UV] <= i_output_under_flag;
      live_r[`PTB_LIVE_OSC] <= i_output_short_flag;
      live_r[`PTB_LIVE_SSC] <= i_sense_pin_short_flag;
      live_r[`PTB_LIVE_V10] <= i_vout_10pct_high;
      live_r[`PTB_LIVE_V4] <= i_vout_4pct_high;
      live_r[`PTB_LIVE_OTP] <= i_over_temp_fault;
      live_r[`PTB_LIVE_CVEN] <= i_voltage_cmd_allowed_flag;
      live_r[`PTB_LIVE_LSR] <= i_line_sense_ready;
      live_r[`PTB_LIVE_DIS] <= i_output_discharge_flag;
      live_r[`PTB_LIVE_RDY] <= i_system_ready;
      live_r[`PTB_LIVE_IEN] <= i_interrupt_enable;
      mode_r <= i_mode_flags;
      dac_r <= i_dac_readback;
      cal_r <= i_cal_offset;
      mask_r <= i_int_mask;
    end
  end

  // --------------------------------------------------------------------
  // Pointer and read-back
  // --------------------------------------------------------------------
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ptr_r <= `PTB_PTR_RST;
    end else if (i_wr_stb && ptr_hit) begin
      ptr_r <= i_wdata[7:0];
    end
  end

  always @* begin
    rdata_nxt = 16'h0000;
    if (ptr_hit) begin
      case (ptr_r)
        `PTB_LIVE_OFS: rdata_nxt = live_r;
        `PTB_MODE_OFS: rdata_nxt = {13'h0000, mode_r};
        `PTB_AVGI_OFS: rdata_nxt = {{(16 - CUR_W){1'b0}}, avg_cur};
        `PTB_AVGV_OFS: rdata_nxt = {{(16 - VOLT_W){1'b0}}, avg_volt};
        `PTB_DAC_OFS: rdata_nxt = dac_r;
        `PTB_DIS_OFS: rdata_nxt = dis_r;
        `PTB_HIST_OFS: rdata_nxt = hist_r;
        `PTB_INT_OFS: rdata_nxt = {mask_r, int_st_r};
        `PTB_TON_OFS: rdata_nxt = {{(12 - TON_W){1'b0}}, ton_sum};
        `PTB_TOFF_OFS: rdata_nxt[TOFF_W+3:0] = toff_sum;
        `PTB_CAL_OFS: rdata_nxt = {12'h000, cal_r};
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  // Writes other than the pointer are dropped; nothing else is writable
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rdata <= 16'h0000;
      o_rd_valid <= 1'b0;
      o_int_req <= 1'b0;
    end else begin
      o_rd_valid <= i_rd_stb;
      if (i_rd_stb) begin
        o_rdata <= rdata_nxt;
      end
      // Mask bit high blocks its status bit; two top events unmaskable
      o_int_req <= |(int_st_r & {2'b11, ~mask_r});
    end
  end

endmodule

`default_nettype wire

/* File: src/ptb_telemetry_defs.vh */
/*
 * Constants for the telemetry read-back bank: access addresses, register
 * sub-addresses, bit positions and window sizes.
 * Assumes it is included by bare name from the files under src/.
 */
`ifndef PTB_TELEMETRY_DEFS_VH
`define PTB_TELEMETRY_DEFS_VH

// ----------------------------------------------------------------------
// Access addresses
// ----------------------------------------------------------------------
`define PTB_PTR_ADDR 8'h80
`define PTB_LIVE_OFS 8'h14
`define PTB_MODE_OFS 8'h16
`define PTB_AVGI_OFS 8'h18
`define PTB_AVGV_OFS 8'h1A
`define PTB_DAC_OFS 8'h1C
`define PTB_DIS_OFS 8'h1E
`define PTB_HIST_OFS 8'h20
`define PTB_INT_OFS 8'h22
`define PTB_TON_OFS 8'h2A
`define PTB_TOFF_OFS 8'h2C
`define PTB_CAL_OFS 8'h2E
`define PTB_PTR_RST 8'h14

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PTB_LIVE_OV 0
`define PTB_LIVE_UV 1
`define PTB_LIVE_OSC 2
`define PTB_LIVE_SSC 3
`define PTB_LIVE_V10 4
`define PTB_LIVE_V4 5
`define PTB_LIVE_OTP 9
`define PTB_LIVE_CVEN 10
`define PTB_LIVE_LSR 12
`define PTB_LIVE_DIS 13
`define PTB_LIVE_RDY 14
`define PTB_LIVE_IEN 15
`define PTB_DIS_WD 0
`define PTB_DIS_UV 1
`define PTB_DIS_OV 2
`define PTB_DIS_SSC 4
`define PTB_DIS_CVO 6
`define PTB_HIST_BPS 0
`define PTB_HIST_LO_LSB 1
`define PTB_HIST_LO_MSB 6
`define PTB_HIST_CMD 7
`define PTB_HIST_AR_LSB 9
`define PTB_HIST_AR_MSB 14
`define PTB_INT_ST_MSB 8
`define PTB_INT_MK_LSB 9
`define PTB_INT_MK_MSB 15
`define PTB_CAL_SIGN 3

// ----------------------------------------------------------------------
// Window sizes
// ----------------------------------------------------------------------
`define PTB_WIN_N 16
`define PTB_WIN_LOG2 4

`endif

/* File: src/ptb_window_sum.v */
/*
 * Sliding sum over the most recent sixteen samples, optionally divided
 * down to a mean by a right shift.
 * Assumes samples arrive as one-cycle valid pulses on i_clk.
 */
`include "ptb_telemetry_defs.vh"
`default_nettype none

module ptb_window_sum #(
  parameter IN_W = 8,
  parameter OUT_W = 8,
  parameter SHIFT = 4
) (
  input wire i_clk,
  input wire i_reset,
  input wire i_valid,
  input wire [IN_W-1:0] i_sample,
  output reg [OUT_W-1:0] o_value
);

  localparam SUM_W = IN_W + `PTB_WIN_LOG2;

  reg [IN_W-1:0] hist_r [0:`PTB_WIN_N-1];
  reg [`PTB_WIN_LOG2-1:0] wr_ptr_r;
  reg [SUM_W-1:0] sum_r;
  wire [SUM_W-1:0] sum_nxt;
  wire [SUM_W-1:0] shifted;
  integer k;

  // Add the newest sample, drop the one it overwrites
  assign sum_nxt = sum_r + {{`PTB_WIN_LOG2{1'b0}}, i_sample}
                   - {{`PTB_WIN_LOG2{1'b0}}, hist_r[wr_ptr_r]};
  assign shifted = sum_r >> SHIFT;

  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      for (k = 0; k < `PTB_WIN_N; k = k + 1) begin
        hist_r[k] <= {IN_W{1'b0}};
      end
      wr_ptr_r <= {`PTB_WIN_LOG2{1'b0}};
      sum_r <= {SUM_W{1'b0}};
    end else if (i_valid) begin
      hist_r[wr_ptr_r] <= i_sample;
      wr_ptr_r <= wr_ptr_r + 1'b1;
      sum_r <= sum_nxt;
    end
  end

  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_value <= {OUT_W{1'b0}};
    end else begin
      o_value <= shifted[OUT_W-1:0];
    end
  end

endmodule

`default_nettype wire

/* File: verification/ptb_bank_props.sv */
/* Assertions on the telemetry bank's read port and field layout.
   Assumes it is bound to ptb_telemetry_bank and sees only its ports. */
`default_nettype none
module ptb_bank_props (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_wr_stb,
  input wire logic i_rd_stb,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic [15:0] o_rdata,
  input wire logic o_rd_valid,
  input wire logic i_output_over_flag,
  input wire logic i_output_under_flag,
  input wire logic i_output_short_flag,
  input wire logic i_sense_pin_short_flag,
  input wire logic i_system_ready,
  input wire logic i_line_sense_ready,
  input wire logic [3:0] i_cal_offset
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] ptr_r;
  logic [7:0] sel_r;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // --------------------------------------------------------------
  // Register picked by each read, 8'hFF when the read address is not the pointer location
  // --------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ptr_r <= 8'h14;
      sel_r <= 8'hFF;
    end else begin
      if (i_wr_stb && i_addr == 8'h80)
        ptr_r <= i_wdata[7:0];
      if (i_rd_stb)
        sel_r <= (i_addr == 8'h80) ? ptr_r : 8'hFF;
    end
  end
  a_read_answer: assert property (i_rd_stb |=> o_rd_valid)
    else $error("read not answered");
  a_valid_single: assert property (!i_rd_stb |=> !o_rd_valid)
    else $error("spurious read valid");
  a_rdata_hold: assert property (!o_rd_valid |-> $stable(o_rdata))
    else $error("read data moved");
  a_unmapped_zero: assert property (
    o_rd_valid && sel_r == 8'hFF |-> o_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_cur_top_zero: assert property (
    o_rd_valid && sel_r == 8'h18 |-> o_rdata[15:8] == 8'h00)
    else $error("current top byte set");
  a_volt_top_zero: assert property (
    o_rd_valid && sel_r == 8'h1A |-> o_rdata[15:12] == 4'h0)
    else $error("voltage top bits set");
  a_ton_top_zero: assert property (
    o_rd_valid && sel_r == 8'h2A |-> o_rdata[15:12] == 4'h0)
    else $error("on-time top bits set");
  a_live_faults: assert property (
    o_rd_valid && sel_r == 8'h14 |->
    o_rdata[0] == $past(i_output_over_flag, 2) &&
    o_rdata[1] == $past(i_output_under_flag, 2) &&
    o_rdata[2] == $past(i_output_short_flag, 2) &&
    o_rdata[3] == $past(i_sense_pin_short_flag, 2))
    else $error("live fault bits wrong");
  a_live_ready: assert property (
    o_rd_valid && sel_r == 8'h14 |->
    o_rdata[14] == $past(i_system_ready, 2) &&
    o_rdata[12] == $past(i_line_sense_ready, 2))
    else $error("live ready bits wrong");
  a_cal_value: assert property (
    o_rd_valid && sel_r == 8'h2E |-> o_rdata[3:0] == $past(i_cal_offset, 2))
    else $error("calibration value wrong");
  c_live: cover property (o_rd_valid && sel_r == 8'h14);
  c_hist: cover property (o_rd_valid && sel_r == 8'h20);
  c_unmapped: cover property (o_rd_valid && sel_r == 8'hFF);
  c_int: cover property (o_rd_valid && sel_r == 8'h22);
endmodule
bind ptb_telemetry_bank ptb_bank_props props_u (.i_clk, .i_reset,
  .i_wr_stb, .i_rd_stb, .i_addr, .i_wdata, .o_rdata, .o_rd_valid,
  .i_output_over_flag, .i_output_under_flag, .i_output_short_flag,
  .i_sense_pin_short_flag, .i_system_ready, .i_line_sense_ready,
  .i_cal_offset);
`default_nettype wire

/* File: verification/ptb_host_model.sv */
/* Host model: sets the read pointer and reads back, as a serial host would.
   Assumes one clock; requests change 1 ns after a rising edge. */
`default_nettype none
module ptb_host_model (
  input wire logic i_clk,
  output logic o_wr_stb,
  output logic o_rd_stb,
  output logic [7:0] o_addr,
  output logic [15:0] o_wdata,
  input wire logic [15:0] i_rdata,
  input wire logic i_rd_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  // --------------------------------------------------------------
  // Access tasks; released lines show the inverse of the last value
  // --------------------------------------------------------------
  initial begin
    o_wr_stb = 1'b0;
    o_rd_stb = 1'b0;
    o_addr = 8'h00;
    o_wdata = 16'h0000;
  end
  task automatic wr_at(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    #1;
    o_wr_stb = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(posedge i_clk);
    #1;
    o_wr_stb = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask
  task automatic rd_at(input logic [7:0] a, output logic [15:0] v);
    int n;
    @(posedge i_clk);
    #1;
    o_rd_stb = 1'b1;
    o_addr = a;
    @(posedge i_clk);
    #1;
    o_rd_stb = 1'b0;
    o_addr = ~a;
    n = 0;
    while (i_rd_valid !== 1'b1 && n < 4) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    v = (i_rd_valid === 1'b1) ? i_rdata : 16'hXXXX;
  endtask
  task automatic rd_reg(input logic [7:0] ofs, output logic [15:0] v);
    repeat ($urandom_range(0, 2)) @(posedge i_clk);
    wr_at(8'h80, {8'h00, ofs});
    rd_at(8'h80, v);
  endtask
endmodule
`default_nettype wire

/* File: verification/tb.sv */
/* Self-checking bench for the telemetry bank.
   Assumes the host model and checker are compiled before it. */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, wr, rd, rvalid, intr, oc, bp;
  logic [7:0] addr, cs, ts;
  logic [15:0] wdata, rdata, lv, dac;
  logic [2:0] mode;
  logic [3:0] cal, vld;
  logic [6:0] mask;
  logic [11:0] vs, fs;
  logic [4:0] dc;
  logic [5:0] rc, lc;
  logic [8:0] ev;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  ptb_telemetry_bank dut_u (
    .i_clk(clk), .i_reset(rst), .i_wr_stb(wr), .i_rd_stb(rd), .i_addr(addr),
    .i_wdata(wdata), .o_rdata(rdata), .o_rd_valid(rvalid), .o_int_req(intr),
    .i_output_over_flag(lv[0]), .i_output_under_flag(lv[1]),
    .i_output_short_flag(lv[2]), .i_sense_pin_short_flag(lv[3]),
    .i_vout_10pct_high(lv[4]), .i_vout_4pct_high(lv[5]),
    .i_over_temp_fault(lv[9]), .i_voltage_cmd_allowed_flag(lv[10]),
    .i_line_sense_ready(lv[12]), .i_output_discharge_flag(lv[13]),
    .i_system_ready(lv[14]), .i_interrupt_enable(lv[15]),
    .i_mode_flags(mode), .i_dac_readback(dac), .i_cal_offset(cal),
    .i_int_mask(mask), .i_cur_valid(vld[0]), .i_cur_sample(cs),
    .i_volt_valid(vld[1]), .i_volt_sample(vs), .i_ton_valid(vld[2]),
    .i_ton_sample(ts), .i_toff_valid(vld[3]), .i_toff_sample(fs),
    .i_overload_disable_cause(dc[4]), .i_sense_short_disable_cause(dc[3]),
    .i_over_disable_cause(dc[2]), .i_under_disable_cause(dc[1]),
    .i_watchdog_disable_cause(dc[0]), .i_restart_causes(rc),
    .i_latch_causes(lc), .i_off_command_received(oc),
    .i_bypass_pin_latch_cause(bp), .i_int_events(ev));
  ptb_host_model host_u (.i_clk(clk), .o_wr_stb(wr), .o_rd_stb(rd),
    .o_addr(addr), .o_wdata(wdata), .i_rdata(rdata), .i_rd_valid(rvalid));
  // --------------------------------------------------------------
  // Clock, watchdog and checking helpers
  // --------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  function automatic logic [15:0] avg16(input logic [15:0] s);
    return s >> 4;
  endfunction
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] ofs, input logic [15:0] exp);
    logic [15:0] v;
    host_u.rd_reg(ofs, v);
    chk(v, exp);
  endtask
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    logic [15:0] v, sc, sv, st, sf, e1, e2;
    {lv, mode, dac, cal, mask, vld, cs, vs, ts, fs, dc, rc, lc, oc, bp} = '0;
    ev = 9'h000;
    rst = 1'b1;
    v = $urandom(58);
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    lv = 16'h4000;
    rdchk(8'h14, 16'h4000);
    repeat (6) begin
      lv = $urandom;
      {mode, dac, cal} = $urandom;
      rdchk(8'h14, lv & 16'hF63F);
      rdchk(8'h16, {13'h0000, mode});
      rdchk(8'h1C, dac);
      rdchk(8'h2E, {12'h000, cal});
    end
    $display("test live done");
    {sc, sv, st, sf} = '0;
    vld = 4'hF;
    for (int j = 0; j < 20; j++) begin
      {cs, vs} = $urandom;
      {ts, fs} = $urandom;
      if (j >= 4) begin
        sc += cs;
        sv += vs;
        st += ts;
        sf += fs;
      end
      step();
    end
    vld = 4'h0;
    rdchk(8'h18, avg16(sc));
    rdchk(8'h1A, avg16(sv));
    rdchk(8'h2A, st);
    rdchk(8'h2C, sf);
    $display("test windows done");
    for (int i = 0; i < 2; i++) begin
      {dc, rc, lc, oc, bp} = (i == 0) ? '1 : $urandom;
      e1 = {9'h000, dc[4], 1'b0, dc[3], 1'b0, dc[2:0]};
      e2 = {1'b0, rc, 1'b0, oc, lc, bp};
      step();
      {dc, rc, lc, oc, bp} = '0;
      rdchk(8'h1E, e1);
      rdchk(8'h20, e2);
      host_u.wr_at(8'h1E, 16'hFFFF);
      host_u.wr_at(8'h20, 16'h0000);
      rdchk(8'h20, e2);
      rst = 1'b1;
      step();
      rst = 1'b0;
      lv[14] = 1'b1;
      rdchk(8'h14, lv & 16'hF63F);
      rdchk(8'h1E, 16'h0000);
      rdchk(8'h20, 16'h0000);
    end
    $display("test causes done");
    mask = 7'h7F;
    ev = 9'h001;
    step();
    ev = 9'h000;
    repeat (3) step();
    chk({15'h0000, intr}, 16'h0000);
    mask = 7'h00;
    repeat (2) step();
    chk({15'h0000, intr}, 16'h0001);
    rdchk(8'h22, 16'h0001);
    repeat (3) step();
    chk({15'h0000, intr}, 16'h0000);
    mask = 7'h7F;
    ev = 9'h100;
    step();
    ev = 9'h000;
    repeat (2) step();
    chk({15'h0000, intr}, 16'h0001);
    rdchk(8'h22, 16'hFF00);
    $display("test interrupts done");
    host_u.rd_at(8'h14, v);
    chk(v, 16'h0000);
    rdchk(8'h24, 16'h0000);
    $display("test unmapped done");
    test_done();
  end
endmodule
`default_nettype wire
